// >>> src/sbi_pkg.sv
package sbi_pkg;
  localparam int ADW = 16;
  localparam int SEGW = 7;
  localparam int STW = 4;
  localparam int FIFO_DEPTH = 8;
  // Cycle status codes
  localparam logic [3:0] ST_INTERNAL = 4'h0;
  localparam logic [3:0] ST_RESET = 4'h1;
  localparam logic [3:0] ST_NMI_ACK = 4'h5;
  localparam logic [3:0] ST_PLAIN_ACK = 4'h6;
  localparam logic [3:0] ST_VEC_ACK = 4'h7;
  localparam logic [3:0] ST_IO = 4'h2;
  localparam logic [3:0] ST_DATA = 4'hA;
  localparam logic [3:0] ST_TRAP = 4'h4;
  localparam logic [3:0] ST_ABORT = 4'h3;
  localparam logic BYTE_LEVEL = 1'b1;
  localparam logic WORD_LEVEL = 1'b0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [6:0] SEG_RESET = 7'h00;

  typedef struct packed {
    logic isWrite;
    logic isIo;
    logic isByte;
    logic sysMode;
    logic [SEGW-1:0] segment;
    logic [ADW-1:0] offset;
    logic [ADW-1:0] wdata;
  } sbi_req_s;

  typedef struct packed {
    logic [ADW-1:0] rdata;
    logic aborted;
  } sbi_rsp_s;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ADDR = 8'h02,
    S_ASEND = 8'h04,
    S_DATA = 8'h08,
    S_DSEND = 8'h10,
    S_GRANT = 8'h20,
    S_INTACK = 8'h40,
    S_STOPPED = 8'h80
  } sbi_state_e;

  typedef enum logic [3:0] {
    IRQ_NONE = 4'h0,
    IRQ_NMI = 4'h1,
    IRQ_VEC = 4'h2,
    IRQ_PLAIN = 4'h4,
    IRQ_TRAP = 4'h8
  } sbi_irq_e;
endpackage

// >>> src/sbi_fifo.sv
`timescale 1ns/1ps
module sbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_badParams
    $error("sbi_fifo needs a power-of-two depth and a nonzero width");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic doWrite, doRead, next_inReady;

  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_comb begin
    next_wrPtr = doWrite ? wrPtr + (AW+1)'(1) : wrPtr;
    next_rdPtr = doRead ? rdPtr + (AW+1)'(1) : rdPtr;
    // Registered full flag, so the upstream ready comes from a flop
    next_inReady = (next_wrPtr - next_rdPtr) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      inReady <= 1'b1;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      inReady <= next_inReady;
    end
    if (doWrite) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule

// >>> src/sbi_bus_interface.sv
`timescale 1ns/1ps
// Function
// - Shared lines carry address first, then data
// - Address valid at address strobe rise
// - Data valid at data strobe rise
// - Grant low only once off the bus
// - Memory cycle output marks memory address
// - NMI on falling edge, highest priority
// - Plain interrupt starts non-vectored handling
// - Vectored interrupt starts vectored handling
// - Wait input stretches the data transfer
// - Abort stops current instruction early
// - Page fault trap interrupts the processor
// - Segment fault trap interrupts the processor
// - Segment number driven for each access
// - Four status lines encode cycle kind
// - Stop input holds for single stepping
// - Reset returns device to reset state
// - Read/write output shows transfer direction
// - Byte/word output shows quantity size
// - Normal/system output shows operating mode
// - Chain input and output join daisy chain
// - Byte/word low for word, high byte
// - Seven segment lines, 128 segments
module sbi_bus_interface
  import sbi_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire sbi_req_s reqData,
  input wire logic reqValid,
  output logic reqReady,
  output sbi_rsp_s rspData,
  output logic rspValid,
  output logic [3:0] irqTaken,
  output logic [15:0] addrDataOut,
  output logic addrDataOe,
  input wire logic [15:0] addrDataIn,
  output logic addr_strobe_n,
  output logic addrStrobeOe,
  output logic data_strobe_n,
  output logic dataStrobeOe,
  output logic memory_cycle_n,
  output logic memCycleOe,
  output logic readWrite,
  output logic rwOe,
  output logic byteWord,
  output logic bwOe,
  output logic normalSystem,
  output logic [6:0] segment_number,
  output logic segOe,
  output logic [3:0] cycle_status_code,
  output logic bus_grant_n,
  input wire logic bus_request_n,
  input wire logic wait_n,
  input wire logic nmi_n,
  input wire logic plain_irq_n,
  input wire logic vector_irq_n,
  input wire logic abort_n,
  input wire logic page_fault_trap_n,
  input wire logic seg_fault_trap_n,
  input wire logic stop_n,
  input wire logic chain_in_n,
  output logic chain_out_n,
  input wire logic chainRequest
);
  if (FIFO_D < 2) begin : g_badDepth
    $error("Request queue depth too small");
  end
  localparam int REQW = $bits(sbi_req_s);

  sbi_state_e state, next_state;
  sbi_req_s cur, next_cur;
  sbi_req_s fifoOut;
  logic fifoValid, fifoPop;
  logic nmiPrev, nmiPend, next_nmiPend, next_nmiPrev, nmiEdge, nmiServe;
  logic [15:0] next_adOut;
  logic next_adOe, next_addrStrobe, next_dataStrobe, next_memCycle, next_rw, next_bw, next_ns, next_busOe;
  logic [6:0] next_seg;
  logic [3:0] next_st, next_irq;
  logic next_grant, next_rspValid, next_chainOut;
  sbi_rsp_s next_rsp;
  logic busOe;

  sbi_fifo #(.WIDTH(REQW), .DEPTH(FIFO_D)) reqFifo (
    .clock(clock),
    .resetn(resetn),
    .inData(reqData),
    .inValid(reqValid),
    .inReady(reqReady),
    .outData(fifoOut),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  assign addrStrobeOe = busOe;
  assign dataStrobeOe = busOe;
  assign memCycleOe = busOe;
  assign rwOe = busOe;
  assign bwOe = busOe;
  assign segOe = busOe;

  assign nmiEdge = nmiPrev & ~nmi_n;

  always_comb begin
    next_state = state;
    next_cur = cur;
    fifoPop = 1'b0;
    nmiServe = 1'b0;
    next_adOut = addrDataOut;
    next_adOe = addrDataOe;
    next_addrStrobe = 1'b1;
    next_dataStrobe = 1'b1;
    next_memCycle = memory_cycle_n;
    next_rw = readWrite;
    next_bw = byteWord;
    next_ns = normalSystem;
    next_seg = segment_number;
    next_st = cycle_status_code;
    next_irq = 4'h0;
    next_grant = bus_grant_n;
    next_busOe = busOe;
    next_rspValid = 1'b0;
    next_rsp = rspData;
    case (state)
      S_IDLE: begin
        next_memCycle = 1'b1;
        next_st = ST_INTERNAL;
        next_adOe = 1'b1;
        if (!bus_request_n) begin
          // Release pins first; grant follows a cycle later
          next_busOe = 1'b1;
          next_state = S_GRANT;
        end else if (nmiPend || nmiEdge) begin
          // A fresh edge is served at once, ahead of trap and interrupt levels; a bus request still wins and the edge stays pending
          nmiServe = 1'b1;
          next_irq = IRQ_NMI;
          next_st = ST_NMI_ACK;
          next_state = S_INTACK;
        end else if (!page_fault_trap_n || !seg_fault_trap_n) begin
          next_irq = IRQ_TRAP;
          next_st = ST_TRAP;
          next_state = S_INTACK;
        end else if (!vector_irq_n) begin
          next_irq = IRQ_VEC;
          next_st = ST_VEC_ACK;
          next_state = S_INTACK;
        end else if (!plain_irq_n) begin
          next_irq = IRQ_PLAIN;
          next_st = ST_PLAIN_ACK;
          next_state = S_INTACK;
        end else if (!stop_n) begin
          next_state = S_STOPPED;
        end else if (fifoValid) begin
          fifoPop = 1'b1;
          next_cur = fifoOut;
          next_adOut = fifoOut.offset;
          next_adOe = 1'b0;
          next_busOe = 1'b0;
          next_seg = fifoOut.segment;
          next_memCycle = fifoOut.isIo;
          next_rw = ~fifoOut.isWrite;
          next_bw = fifoOut.isByte ? BYTE_LEVEL : WORD_LEVEL;
          next_ns = ~fifoOut.sysMode;
          next_st = fifoOut.isIo ? ST_IO : ST_DATA;
          next_addrStrobe = 1'b0;
          next_state = S_ADDR;
        end
      end
      S_ADDR: begin
        next_addrStrobe = 1'b1;
        next_state = S_ASEND;
      end
      S_ASEND: begin
        next_adOut = cur.wdata;
        next_adOe = ~cur.isWrite;
        next_dataStrobe = 1'b0;
        next_state = S_DATA;
      end
      S_DATA: begin
        if (!abort_n) begin
          next_dataStrobe = 1'b1;
          next_rsp.aborted = 1'b1;
          next_rsp.rdata = 16'h0000;
          next_rspValid = 1'b1;
          next_st = ST_ABORT;
          next_state = S_DSEND;
        end else if (!wait_n) begin
          next_dataStrobe = 1'b0;
        end else begin
          next_dataStrobe = 1'b1;
          next_rsp.rdata = cur.isWrite ? 16'h0000 : addrDataIn;
          next_rsp.aborted = 1'b0;
          next_rspValid = 1'b1;
          next_state = S_DSEND;
        end
      end
      S_DSEND: begin
        next_adOe = 1'b1;
        next_memCycle = 1'b1;
        next_state = S_IDLE;
      end
      S_GRANT: begin
        next_grant = bus_request_n;
        if (bus_request_n && !bus_grant_n) begin
          next_grant = 1'b1;
          next_busOe = 1'b0;
          next_state = S_IDLE;
        end else if (bus_request_n) begin
          next_busOe = 1'b0;
          next_state = S_IDLE;
        end
      end
      S_INTACK: begin
        next_state = S_IDLE;
      end
      S_STOPPED: begin
        if (stop_n) next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= S_IDLE;
      cur <= '0;
      addrDataOut <= ADDR_RESET;
      addrDataOe <= 1'b1;
      addr_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      memory_cycle_n <= 1'b1;
      readWrite <= 1'b1;
      byteWord <= WORD_LEVEL;
      normalSystem <= 1'b0;
      segment_number <= SEG_RESET;
      cycle_status_code <= ST_RESET;
      irqTaken <= 4'h0;
      bus_grant_n <= 1'b1;
      busOe <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      addrDataOut <= next_adOut;
      addrDataOe <= next_adOe;
      addr_strobe_n <= next_addrStrobe;
      data_strobe_n <= next_dataStrobe;
      memory_cycle_n <= next_memCycle;
      readWrite <= next_rw;
      byteWord <= next_bw;
      normalSystem <= next_ns;
      segment_number <= next_seg;
      cycle_status_code <= next_st;
      irqTaken <= next_irq;
      bus_grant_n <= next_grant;
      busOe <= next_busOe;
      rspValid <= next_rspValid;
      rspData <= next_rsp;
    end
  end

  // Set wins: an edge arriving while an older one is served stays pending
  always_comb begin
    next_nmiPrev = nmi_n;
    if (nmiServe) begin
      next_nmiPend = nmiPend & nmiEdge;
    end else begin
      next_nmiPend = nmiPend | nmiEdge;
    end
  end

  // Previous level starts high, so an NMI line held low at release of reset counts as an edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      nmiPrev <= 1'b1;
      nmiPend <= 1'b0;
    end else begin
      nmiPrev <= next_nmiPrev;
      nmiPend <= next_nmiPend;
    end
  end

  always_comb begin
    next_chainOut = ~(chainRequest & ~chain_in_n);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      chain_out_n <= 1'b1;
    end else begin
      chain_out_n <= next_chainOut;
    end
  end
endmodule

// >>> dv/sbi_target_model.sv
`timescale 1ns/1ps
module sbi_target_model (
  input wire logic clock,
  input wire logic data_strobe_n,
  input wire logic readWrite,
  input wire logic addrDataOe,
  input wire logic [15:0] addrDataOut,
  input wire logic [15:0] readValue,
  input wire logic [7:0] waitCycles,
  output logic wait_n,
  output logic [15:0] addrDataIn
);
  logic [7:0] held = 8'h00;
  logic [15:0] last = 16'h0000;
  always @(posedge clock) begin
    held <= data_strobe_n ? 8'h00 : held + 8'h01;
    if (!addrDataOe) last <= addrDataOut;
  end
  // Slow target holds the data phase open
  assign wait_n = data_strobe_n || held >= waitCycles;
  // Released lines show the inverse, never a stale copy
  assign addrDataIn = (!data_strobe_n && readWrite) ? readValue : ~last;
endmodule

// >>> dv/sbi_bus_interface_assertions.sv
`timescale 1ns/1ps
module sbi_checker
  import sbi_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic rspValid,
  input wire logic [3:0] irqTaken,
  input wire logic [15:0] addrDataOut,
  input wire logic addrDataOe,
  input wire logic addr_strobe_n,
  input wire logic addrStrobeOe,
  input wire logic data_strobe_n,
  input wire logic memory_cycle_n,
  input wire logic [3:0] cycle_status_code,
  input wire logic bus_grant_n,
  input wire logic bus_request_n,
  input wire logic wait_n,
  input wire logic abort_n,
  input wire logic chain_in_n,
  input wire logic chain_out_n,
  input wire logic chainRequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  addr_hold_a:
    assert property ($rose(addr_strobe_n) |-> !addrDataOe && $stable(addrDataOut)) else $error("address moved");
  phase_order_a:
    assert property ($fell(addr_strobe_n) |-> ##2 !data_strobe_n && addr_strobe_n) else $error("data phase late");
  wait_hold_a:
    assert property (!data_strobe_n && !wait_n && abort_n |=> !data_strobe_n) else $error("wait ignored");
  bus_float_a:
    assert property (!bus_grant_n |-> addrDataOe && addrStrobeOe) else $error("driving while granted");
  grant_after_a:
    assert property ($fell(bus_grant_n) |-> $past(addrStrobeOe) && !$past(bus_request_n)) else $error("early grant");
  cycle_kind_a:
    assert property ($fell(addr_strobe_n) |-> cycle_status_code == (memory_cycle_n ? ST_IO : ST_DATA))
      else $error("wrong cycle kind");
  data_mark_a:
    assert property (rspValid |-> $rose(data_strobe_n)) else $error("answer without strobe rise");
  nmi_code_a:
    assert property (irqTaken == 4'h1 |-> cycle_status_code == ST_NMI_ACK) else $error("wrong NMI status");
  chain_out_a:
    assert property (chain_out_n != ($past(chainRequest) & !$past(chain_in_n))) else $error("chain output wrong");
  cover property (!bus_grant_n);
  cover property (!data_strobe_n && !wait_n);
  cover property (irqTaken == 4'h1);
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top import sbi_pkg::*;;
  logic clock = 1'h0, resetn = 1'h0, reqValid = 1'h0, chainRequest = 1'h0, bus_request_n = 1'h1;
  logic nmi_n = 1'h1, plain_irq_n = 1'h1, vector_irq_n = 1'h1, abort_n = 1'h1, chain_in_n = 1'h1;
  logic page_fault_trap_n = 1'h1, seg_fault_trap_n = 1'h1, stop_n = 1'h1, addrStrobePrev = 1'h1;
  sbi_req_s reqData = '0;
  sbi_rsp_s rspData;
  logic reqReady, rspValid, addrDataOe, addr_strobe_n, addrStrobeOe, data_strobe_n, dataStrobeOe;
  logic memory_cycle_n, memCycleOe, readWrite, rwOe, byteWord, bwOe, normalSystem, segOe, bus_grant_n;
  logic chain_out_n, wait_n;
  logic [3:0] irqTaken, cycle_status_code;
  logic [15:0] addrDataOut, addrDataIn, dataSeen, readValue = 16'h0000;
  logic [6:0] segment_number;
  logic [7:0] waitCycles = 8'h00;
  logic [31:0] addrSeen;
  int fail_count = 0, checks = 0;
  sbi_bus_interface i_sbi_bus_interface (.*);
  sbi_target_model i_sbi_target_model (.*);
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    addrStrobePrev <= addr_strobe_n;
    if (!addr_strobe_n && addrStrobePrev)
      addrSeen <= {1'b0, cycle_status_code, memory_cycle_n, readWrite, byteWord, normalSystem, segment_number, addrDataOut};
    // What stands while the strobe is low is what its rise marks
    if (!data_strobe_n) dataSeen <= addrDataOut;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic xfer(logic w, io, b, s, logic [6:0] sg, logic [15:0] off, wd, logic [7:0] wc, logic ab);
    int n;
    n = 0;
    @(posedge clock);
    waitCycles <= wc;
    readValue <= ~wd;
    abort_n <= ~ab;
    reqData <= '{w, io, b, s, sg, off, wd};
    reqValid <= 1'h1;
    @(posedge clock);
    reqValid <= 1'h0;
    while (rspValid !== 1'h1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    abort_n <= 1'h1;
    chk("rsp", 32'h1, {31'h0, rspValid});
    chk("aborted", {31'h0, ab}, {31'h0, rspData.aborted});
    chk("kind", {28'h0, io ? ST_IO : ST_DATA}, {28'h0, addrSeen[30:27]});
    chk("addr", {5'h0, io, !w, b, !s, sg, off}, {5'h0, addrSeen[26:0]});
    if (w) chk("wdata", {16'h0, wd}, {16'h0, dataSeen});
    else if (!ab) chk("rdata", {16'h0, ~wd}, {16'h0, rspData.rdata});
  endtask
  task automatic irq(logic [4:0] lines, logic [3:0] exp);
    int n;
    n = 0;
    {nmi_n, vector_irq_n, plain_irq_n, page_fault_trap_n, seg_fault_trap_n} <= ~lines;
    while (irqTaken === 4'h0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    {nmi_n, vector_irq_n, plain_irq_n, page_fault_trap_n, seg_fault_trap_n} <= 5'h1F;
    chk("irq", {28'h0, exp}, {28'h0, irqTaken});
    repeat (6) @(posedge clock);
  endtask
  task automatic grant_test();
    int n;
    n = 0;
    bus_request_n <= 1'h0;
    while (bus_grant_n !== 1'h0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    chk("granted", 32'h0, {31'h0, bus_grant_n});
    chk("float", 32'h7F, {25'h0, addrDataOe, addrStrobeOe, dataStrobeOe, memCycleOe, rwOe, bwOe, segOe});
    bus_request_n <= 1'h1;
    repeat (4) @(posedge clock);
    chk("grant", 32'h2, {30'h0, bus_grant_n, addrStrobeOe});
  endtask
  task automatic fill_drain();
    int n;
    int r;
    n = 0;
    r = 0;
    stop_n <= 1'h0;
    repeat (2) @(posedge clock);
    reqValid <= 1'h1;
    repeat (12) begin
      @(posedge clock);
      if (reqReady === 1'h1) n++;
    end
    reqValid <= 1'h0;
    chk("fill", FIFO_DEPTH, n);
    stop_n <= 1'h1;
    repeat (200) begin
      @(posedge clock);
      if (rspValid === 1'h1) r++;
    end
    chk("drain", FIFO_DEPTH, r);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    chk("reset", {ST_RESET, 4'hF}, {cycle_status_code, addr_strobe_n, data_strobe_n, bus_grant_n, addrDataOe});
    resetn <= 1'h1;
    xfer(1'h1, 1'h0, 1'h0, 1'h1, 7'h7F, 16'hFFFF, 16'hA55A, 8'h00, 1'h0);
    xfer(1'h0, 1'h1, 1'h1, 1'h0, 7'h00, 16'h0001, 16'h3C96, 8'h03, 1'h0);
    xfer(1'h0, 1'h0, 1'h0, 1'h0, 7'h15, 16'h8000, 16'h1234, 8'h04, 1'h1);
    grant_test();
    irq(5'h18, 4'h1);
    irq(5'h08, 4'h2);
    irq(5'h04, 4'h4);
    irq(5'h02, 4'h8);
    irq(5'h01, 4'h8);
    chainRequest <= 1'h1;
    chain_in_n <= 1'h0;
    repeat (3) @(posedge clock);
    chk("chain", 32'h0, {31'h0, chain_out_n});
    fill_drain();
    close_out();
  end
  initial begin
    #20000;
    fail_count++;
    close_out();
  end
endmodule
bind sbi_bus_interface sbi_checker i_sbi_checker (.*);
